// ### rtl/isl_byte_lane.sv
`timescale 1ns/1ps
// Reorders one 32-bit word for big- or little-endian byte order
module isl_byte_lane (
  // Word in and out
  input wire logic [31:0] word_in,
  input wire logic big_endian,
  output logic [31:0] word_out
);
  // Byte 0 sits at the lowest address; big-endian puts it in the top lane
  always_comb begin
    if (big_endian) begin
      word_out = {word_in[7:0], word_in[15:8], word_in[23:16], word_in[31:24]};
    end else begin
      word_out = word_in;
    end
  end
endmodule

// ### rtl/isl_core_ctrl.sv
`timescale 1ns/1ps
// How it works
// - Identity register is read-only at all levels and reads zero.
// - OS control register reads zero, ignores writes, privileged levels only.
// - OS control access from unprivileged level is refused as undefined.
// - Main configuration is write-only unprivileged, read-write when privileged.
// - Main configuration bits are all reserved: read zero, writes ignored.
// - Registers sit on coprocessor 14, opcode1 7, CRm 0, opcode2 0.
// - Branch-exchange-to-bytecode behaves as plain branch-exchange, no acceleration.
// - Status bits 00 base, 01 compact, 11 execution-environment variant.
// - The bytecode bit is never set while the compact bit is clear.
// - Base fetches word-aligned 32-bit; compact fetches halfword-aligned 16/32-bit.
// - Switching base and compact keeps mode and registers unchanged.
// - Reset enters supervisor mode, secure, with non-secure bit clear.
// - Write lock high makes protected writes undefined; reads still complete.
// - Lock change affects newly decoded instructions as soon as possible.
// - Bytes number upward from zero; data words big- or little-endian.
// - Instruction fetches are always little-endian.
// - Physical addresses are up to 40 bits wide.
module isl_core_ctrl
  import isl_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Per-core secure register write lock from SoC logic
  input wire logic secure_sysreg_write_lock,
  // Coprocessor access request, one-cycle valid
  input wire logic cp_valid,
  input wire logic cp_write,
  input wire logic [3:0] cp_num,
  input wire logic [2:0] cp_op1,
  input wire logic [3:0] cp_crn,
  input wire logic [3:0] cp_crm,
  input wire logic [2:0] cp_op2,
  input wire logic [31:0] cp_wdata,
  input wire logic cp_protected,
  // Coprocessor answer
  output logic cp_done,
  output logic cp_undef,
  output logic [31:0] cp_rdata,
  // Branch-exchange request, one-cycle valid
  input wire logic br_valid,
  input wire logic br_to_bytecode,
  input wire logic [31:0] br_target,
  // Instruction-set state change from other sources
  input wire logic iset_load,
  input wire logic iset_t_in,
  input wire logic iset_j_in,
  // Mode and security state loads
  input wire logic mode_load,
  input wire logic [4:0] mode_in,
  input wire logic ns_load,
  input wire logic ns_in,
  // Fetch and data path
  input wire logic [31:0] fetch_addr,
  input wire logic [31:0] fetch_raw,
  input wire logic [31:0] data_raw,
  input wire logic data_big_endian,
  input wire logic [ISL_PA_WIDTH-1:0] phys_addr_in,
  // State outputs
  output logic [31:0] program_status_word,
  output logic nonsecure_state_bit,
  output isl_iset_t iset,
  output logic fetch_misaligned,
  output logic [1:0] fetch_size_min,
  output logic [31:0] fetch_word,
  output logic [31:0] data_word,
  output logic [ISL_PA_WIDTH-1:0] phys_addr,
  output logic [31:0] branch_pc
);

  // Lock stage
  logic lock_q;
  logic next_lock_q;
  // Coprocessor answer stage
  logic next_cp_done;
  logic next_cp_undef;
  logic [31:0] next_cp_rdata;
  // Status word, security state and branch target
  logic [31:0] next_psw;
  logic next_ns;
  logic [31:0] next_branch_pc;
  // Fetch and data path stage
  logic [31:0] next_fetch_word;
  logic [31:0] next_data_word;
  logic [ISL_PA_WIDTH-1:0] next_phys_addr;
  logic next_misaligned;
  // Decode helpers, all combinational
  logic [31:0] data_swapped;
  logic privileged;
  logic sel_bytecode;
  logic tj_t;
  logic tj_j;
  logic t_new;
  logic j_new;

  // Data word byte reordering; fetches bypass it
  // Only data accesses honour the endian select input
  // Instruction words keep the lane order they arrived in
  // A swap on the fetch path would corrupt every decode
  isl_byte_lane u_data_lane (
    .word_in(data_raw),
    .big_endian(data_big_endian),
    .word_out(data_swapped)
  );

  // Privilege follows the mode field of the status word
  // Every mode other than user counts as level one or higher
  // Mode loads take one cycle, so a request in the same cycle
  // as a mode load is still judged on the old mode
  assign privileged = (program_status_word[4:0] != ISL_MODE_USER);
  assign tj_t = program_status_word[ISL_PSW_T_BIT];
  assign tj_j = program_status_word[ISL_PSW_J_BIT];

  // Coprocessor 14 group select for the bytecode registers
  // CRn is decoded later, inside the group
  // Accesses outside the group answer with zero read data
  assign sel_bytecode = (cp_num == ISL_CP_NUM) && (cp_op1 == ISL_OP1) &&
                        (cp_crm == ISL_CRM) && (cp_op2 == ISL_OP2);

  // Lock sampled once so a decode sees a stable level
  // The pin may move at any time relative to a request
  // Costs one cycle of latency, which software covers with a barrier
  // A change is seen by requests taken from the second edge after the pin moves
  always_comb begin
    next_lock_q = secure_sysreg_write_lock;
  end

  // Decode of register accesses; answer one cycle after the request
  // Lock check comes first so no protected write slips past it
  // Reads are never refused by the lock
  // All bytecode registers are stubs: write data is dropped
  // and every completed read returns zero
  always_comb begin
    next_cp_done = 1'b0;
    next_cp_undef = 1'b0;
    next_cp_rdata = 32'h0000_0000;
    if (cp_valid) begin
      next_cp_done = 1'b1;
      if (cp_write && cp_protected && lock_q) begin
        // Registered lock applies to the very next decoded write
        next_cp_undef = 1'b1;
      end else if (sel_bytecode) begin
        unique case (cp_crn)
          ISL_CRN_IDENTITY: begin
            if (cp_write) begin
              next_cp_undef = 1'b1;
            end else begin
              next_cp_rdata = ISL_RST_IDENTITY;
            end
          end
          ISL_CRN_OS_CONTROL: begin
            if (!privileged) begin
              next_cp_undef = 1'b1;
            end else begin
              next_cp_rdata = ISL_RST_OS_CONTROL;
            end
          end
          ISL_CRN_MAIN_CONFIG: begin
            if (!privileged && !cp_write) begin
              next_cp_undef = 1'b1;
            end else begin
              next_cp_rdata = ISL_RST_MAIN_CONFIG;
            end
          end
          default: begin
            next_cp_undef = 1'b1;
          end
        endcase
      end else if (!cp_write) begin
        // Reads outside the group complete normally, returning zero here
        next_cp_rdata = 32'h0000_0000;
      end
    end
  end

  // Status word, branch and security state next values
  // Branch has priority over a direct state load
  // The bytecode variant of branch-exchange is not told apart
  // Only the two state bits move on a state change
  always_comb begin
    next_psw = program_status_word;
    next_ns = nonsecure_state_bit;
    next_branch_pc = branch_pc;
    t_new = tj_t;
    j_new = tj_j;
    if (br_valid) begin
      // Bytecode variant takes exactly the plain path
      next_branch_pc = {br_target[31:1], 1'b0};
      t_new = br_target[0];
      j_new = 1'b0;
    end else if (iset_load) begin
      t_new = iset_t_in;
      j_new = iset_j_in;
    end
    // Bytecode state unsupported: J without T is never entered
    if (j_new && !t_new) begin
      j_new = 1'b0;
    end
    // Only T and J change; mode field and registers untouched
    next_psw[ISL_PSW_T_BIT] = t_new;
    next_psw[ISL_PSW_J_BIT] = j_new;
    if (mode_load) begin
      next_psw[4:0] = mode_in;
    end
    if (ns_load) begin
      next_ns = ns_in;
    end
  end

  // Fetch checks and data path registers
  // Alignment is judged against the registered state
  // A fetch in the cycle of a state change uses the old rules
  // Addresses pass through; the translation itself lives elsewhere
  always_comb begin
    next_misaligned = 1'b0;
    unique case (iset)
      ISL_ISET_BASE: begin
        next_misaligned = |(fetch_addr[1:0] & ISL_ALIGN_WORD_MASK);
      end
      ISL_ISET_COMPACT, ISL_ISET_EXEC_ENV: begin
        next_misaligned = |(fetch_addr[1:0] & ISL_ALIGN_HALF_MASK);
      end
    endcase
    next_fetch_word = fetch_raw;
    next_data_word = data_swapped;
    next_phys_addr = phys_addr_in;
  end

  // Instruction-set state decode from J and T
  // J set with T clear can never be loaded
  // so the default arm only covers the base code
  always_comb begin
    unique case ({tj_j, tj_t})
      2'b01: iset = ISL_ISET_COMPACT;
      2'b11: iset = ISL_ISET_EXEC_ENV;
      default: iset = ISL_ISET_BASE; // J-only never reached
    endcase
    fetch_size_min = (iset == ISL_ISET_BASE) ? 2'h2 : 2'h1;
  end

  // Lock register; clears in reset so the first decode is never locked
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lock_q <= 1'b0;
    end else begin
      lock_q <= next_lock_q;
    end
  end

  // Coprocessor answer registers; the answer stands for one cycle only
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cp_done <= 1'b0;
      cp_undef <= 1'b0;
      cp_rdata <= 32'h0000_0000;
    end else begin
      cp_done <= next_cp_done;
      cp_undef <= next_cp_undef;
      cp_rdata <= next_cp_rdata;
    end
  end

  // Status word and security state; reset boots secure supervisor
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      program_status_word <= {27'h0, ISL_MODE_SUPERVISOR};
      nonsecure_state_bit <= 1'b0;
      branch_pc <= 32'h0000_0000;
    end else begin
      program_status_word <= next_psw;
      nonsecure_state_bit <= next_ns;
      branch_pc <= next_branch_pc;
    end
  end

  // Fetch and data path registers; one cycle of latency, no buffering
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fetch_word <= 32'h0000_0000;
      data_word <= 32'h0000_0000;
      phys_addr <= '0;
      fetch_misaligned <= 1'b0;
    end else begin
      fetch_word <= next_fetch_word;
      data_word <= next_data_word;
      phys_addr <= next_phys_addr;
      fetch_misaligned <= next_misaligned;
    end
  end

endmodule

// ### rtl/isl_pkg.sv
package isl_pkg;
  // Coprocessor selector for the bytecode extension registers
  localparam logic [3:0] ISL_CP_NUM = 4'he;
  localparam logic [2:0] ISL_OP1 = 3'h7;
  localparam logic [3:0] ISL_CRM = 4'h0;
  localparam logic [2:0] ISL_OP2 = 3'h0;
  // Register select on CRn
  localparam logic [3:0] ISL_CRN_IDENTITY = 4'h0;
  localparam logic [3:0] ISL_CRN_OS_CONTROL = 4'h1;
  localparam logic [3:0] ISL_CRN_MAIN_CONFIG = 4'h2;
  // Reset values, all three registers read as zero
  localparam logic [31:0] ISL_RST_IDENTITY = 32'h0000_0000;
  localparam logic [31:0] ISL_RST_OS_CONTROL = 32'h0000_0000;
  localparam logic [31:0] ISL_RST_MAIN_CONFIG = 32'h0000_0000;
  // Program status word field positions
  localparam int ISL_PSW_T_BIT = 5;
  localparam int ISL_PSW_J_BIT = 24;
  localparam logic [4:0] ISL_MODE_SUPERVISOR = 5'h13;
  localparam logic [4:0] ISL_MODE_USER = 5'h10;
  // Physical address width and fetch alignment
  localparam int ISL_PA_WIDTH = 40;
  localparam logic [1:0] ISL_ALIGN_WORD_MASK = 2'h3;
  localparam logic [1:0] ISL_ALIGN_HALF_MASK = 2'h1;

  typedef enum logic [1:0] {
    ISL_ISET_BASE,
    ISL_ISET_COMPACT,
    ISL_ISET_EXEC_ENV
  } isl_iset_t;
endpackage

// ### sim/isl_chk_checker.sv
`timescale 1ns/1ps
module isl_chk
  import isl_pkg::*;
(
  // Clock, reset and lock
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic secure_sysreg_write_lock,
  // Coprocessor request and answer
  input wire logic cp_valid,
  input wire logic cp_write,
  input wire logic [3:0] cp_num,
  input wire logic [2:0] cp_op1,
  input wire logic [3:0] cp_crn,
  input wire logic cp_protected,
  input wire logic cp_done,
  input wire logic cp_undef,
  input wire logic [31:0] cp_rdata,
  // Branch, state and fetch
  input wire logic br_valid,
  input wire logic [31:0] br_target,
  input wire logic mode_load,
  input wire logic [31:0] branch_pc,
  input wire logic [31:0] fetch_raw,
  input wire logic [31:0] fetch_word,
  input wire logic [31:0] program_status_word,
  input wire logic nonsecure_state_bit,
  input wire isl_iset_t iset,
  input wire logic [1:0] fetch_size_min
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Request aimed at the bytecode register group
  logic grp;
  assign grp = cp_valid && cp_num == ISL_CP_NUM && cp_op1 == ISL_OP1;
  // Lock must have been seen for a full cycle since it is registered first
  sequence s_lock_wr;
    secure_sysreg_write_lock && $past(secure_sysreg_write_lock) && !$past(rst)
      && cp_valid && cp_write && cp_protected;
  endsequence
  sequence s_br;
    br_valid && !mode_load;
  endsequence
  property p_done; cp_valid |=> cp_done; endproperty
  property p_zero; cp_done |-> cp_rdata == 32'h0000_0000; endproperty
  property p_lock; s_lock_wr |=> cp_done && cp_undef; endproperty
  property p_id; grp && !cp_write && cp_crn == ISL_CRN_IDENTITY |=> !cp_undef; endproperty
  property p_user;
    grp && cp_crn == ISL_CRN_OS_CONTROL && program_status_word[4:0] == ISL_MODE_USER
      |=> cp_undef;
  endproperty
  property p_nojz;
    program_status_word[ISL_PSW_J_BIT] |-> program_status_word[ISL_PSW_T_BIT];
  endproperty
  property p_rst;
    disable iff (1'b0) rst |=> program_status_word == {27'h0, ISL_MODE_SUPERVISOR}
      && !nonsecure_state_bit;
  endproperty
  property p_br;
    s_br |=> branch_pc == ($past(br_target) & 32'hffff_fffe)
      && program_status_word[4:0] == $past(program_status_word[4:0]);
  endproperty
  property p_fsz; iset == ISL_ISET_BASE |-> fetch_size_min == 2'h2; endproperty
  property p_fetch; !$past(rst) |-> fetch_word == $past(fetch_raw); endproperty
  a_done: assert property (p_done) else $error("no answer");
  a_zero: assert property (p_zero) else $error("rdata not zero");
  a_lock: assert property (p_lock) else $error("locked write done");
  a_id: assert property (p_id) else $error("identity read refused");
  a_user: assert property (p_user) else $error("user os access");
  a_nojz: assert property (p_nojz) else $error("bytecode state");
  a_rst: assert property (p_rst) else $error("reset state");
  a_br: assert property (p_br) else $error("branch target");
  a_fsz: assert property (p_fsz) else $error("fetch size");
  a_fetch: assert property (p_fetch) else $error("fetch order");
endmodule
bind isl_core_ctrl isl_chk u_chk (.*);

// ### sim/isl_soc_lock.sv
`timescale 1ns/1ps
module isl_soc_lock (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Boot finished
  input wire logic boot_done,
  // Lock to one core only
  output logic secure_sysreg_write_lock
);
  // Sticky, so secure setup cannot be reopened short of reset
  always_ff @(posedge clk_sys) begin
    secure_sysreg_write_lock <= rst ? 1'b0 : (secure_sysreg_write_lock | boot_done);
  end
endmodule

// ### sim/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end
module tb;
  import isl_pkg::*;
  logic clk_sys, rst, boot, lock, cpv, cpw, cpp, brv, brj, il, it, ij, ml, nl, ni, big;
  logic [3:0] crn;
  logic [4:0] mi;
  logic [31:0] wd, bt, fa, fr, dr, rd, psw, bpc, fw, dw;
  logic [39:0] pi, pa;
  logic done, und, mis, ns;
  logic [1:0] fsz;
  isl_iset_t iset;
  int errors, samples_checked;
  isl_soc_lock u_lock (.clk_sys(clk_sys), .rst(rst), .boot_done(boot),
    .secure_sysreg_write_lock(lock));
  isl_core_ctrl DUT (.clk_sys(clk_sys), .rst(rst), .secure_sysreg_write_lock(lock),
    .cp_valid(cpv), .cp_write(cpw), .cp_num(ISL_CP_NUM), .cp_op1(ISL_OP1), .cp_crn(crn),
    .cp_crm(ISL_CRM), .cp_op2(ISL_OP2), .cp_wdata(wd), .cp_protected(cpp), .cp_done(done),
    .cp_undef(und), .cp_rdata(rd), .br_valid(brv), .br_to_bytecode(brj), .br_target(bt),
    .iset_load(il), .iset_t_in(it), .iset_j_in(ij), .mode_load(ml), .mode_in(mi),
    .ns_load(nl), .ns_in(ni), .fetch_addr(fa), .fetch_raw(fr), .data_raw(dr),
    .data_big_endian(big), .phys_addr_in(pi), .program_status_word(psw),
    .nonsecure_state_bit(ns), .iset(iset), .fetch_misaligned(mis), .fetch_size_min(fsz),
    .fetch_word(fw), .data_word(dw), .phys_addr(pa), .branch_pc(bpc));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask
  // One access, with a gap before it so the strobe never toggles twice in a step
  task automatic cp(input logic w, input logic [3:0] n, input logic p, input logic u);
    step();
    cpw = w;
    crn = n;
    cpp = p;
    cpv = 1'b1;
    step();
    cpv = 1'b0;
    `CHK("cp_done", 1'b1, done)
    `CHK("cp_undef", u, und)
    `CHK("cp_rdata", 32'h0000_0000, rd)
  endtask
  task automatic ld(input logic t, input logic j);
    step();
    it = t;
    ij = j;
    il = 1'b1;
    step();
    il = 1'b0;
  endtask
  task automatic t_regs(input logic [4:0] m, input logic u);
    step();
    mi = m;
    ml = 1'b1;
    step();
    ml = 1'b0;
    cp(1'b0, ISL_CRN_IDENTITY, 1'b0, 1'b0);
    cp(1'b1, ISL_CRN_IDENTITY, 1'b0, 1'b1);
    cp(1'b0, ISL_CRN_OS_CONTROL, 1'b0, u);
    cp(1'b1, ISL_CRN_OS_CONTROL, 1'b0, u);
    cp(1'b1, ISL_CRN_MAIN_CONFIG, 1'b0, 1'b0);
    cp(1'b0, ISL_CRN_MAIN_CONFIG, 1'b0, u);
    cp(1'b0, 4'h3, 1'b0, 1'b1);
  endtask
  task automatic t_iset();
    step();
    bt = 32'h0000_0101;
    brv = 1'b1;
    step();
    brv = 1'b0;
    `CHK("branch_pc", 32'h0000_0100, bpc)
    `CHK("iset", ISL_ISET_COMPACT, iset)
    `CHK("mode", ISL_MODE_SUPERVISOR, psw[4:0])
    `CHK("fsz", 2'h1, fsz)
    ld(1'b0, 1'b1);
    `CHK("j_bit", 1'b0, psw[ISL_PSW_J_BIT])
    ld(1'b1, 1'b1);
    `CHK("iset", ISL_ISET_EXEC_ENV, iset)
    ld(1'b0, 1'b0);
    `CHK("iset", ISL_ISET_BASE, iset)
  endtask
  task automatic t_data();
    big = 1'b1;
    dr = 32'h1122_3344;
    fr = 32'h1122_3344;
    pi = 40'h80_0000_0001;
    ni = 1'b1;
    nl = 1'b1;
    step();
    nl = 1'b0;
    `CHK("data_word", 32'h4433_2211, dw)
    `CHK("fetch_word", 32'h1122_3344, fw)
    `CHK("phys_addr", 40'h80_0000_0001, pa)
    `CHK("ns", 1'b1, ns)
    big = 1'b0;
    fa = 32'h0000_0002;
    step();
    `CHK("data_word_le", 32'h1122_3344, dw)
    `CHK("fetch_misaligned", 1'b1, mis)
  endtask
  task automatic t_lock();
    boot = 1'b1;
    repeat (3) step();
    cp(1'b1, ISL_CRN_OS_CONTROL, 1'b1, 1'b1);
    cp(1'b0, ISL_CRN_OS_CONTROL, 1'b1, 1'b0);
  endtask
  task automatic complete_run();
    if (errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Whole run is well under a thousand cycles
  initial begin
    #200000;
    errors++;
    complete_run();
  end
  initial begin
    rst = 1'b1;
    {boot, cpv, cpw, cpp, brv, brj, il, it, ij, ml, nl, ni, big, crn, mi} = '0;
    {bt, fa, fr, dr, pi} = '0;
    wd = 32'hffff_ffff;
    repeat (5) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    `CHK("psw", 32'h0000_0013, psw)
    `CHK("ns", 1'b0, ns)
    brj = 1'b1;
    t_regs(ISL_MODE_SUPERVISOR, 1'b0);
    t_regs(ISL_MODE_USER, 1'b1);
    t_regs(ISL_MODE_SUPERVISOR, 1'b0);
    t_iset();
    t_data();
    t_lock();
    complete_run();
  end
endmodule
